// >>> rtl/gpm_pkg.sv
// package for the general output pin mux: register layout and codes
// assumes a single 200 MHz clock domain and a register write port
package gpm_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [5:0] OUTPUT_PIN_SOURCE_CONTROL_ADDR = 6'h0F; // offset
  localparam int REG_W = 24; // register width
  localparam logic [23:0] CTRL_RESET = 24'h000001; // reset value
  // field positions
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 5;
  localparam int TEST_DATA_BIT = 5;
  localparam int HOLD_OUTPUT_ONLY_BIT = 6;
  localparam int PIN_DRIVER_FORCE_ON_BIT = 7;
  localparam int PULLUP_OFF_BIT = 8;
  localparam int PULLDOWN_OFF_BIT = 9;
  localparam int USED_BITS = 10; // bits above read as zero
  // source codes with special meaning
  localparam logic [4:0] SRC_TEST_DATA = 5'h00;
  localparam logic [4:0] SRC_LOCK_DETECT = 5'h01;
  localparam logic [4:0] SRC_LOCK_TRIGGER = 5'h02;
  localparam logic [4:0] SRC_LOCK_WINDOW = 5'h03;
  localparam logic [4:0] SRC_UNUSED_LO = 5'h1A;
  localparam logic [4:0] SRC_UNUSED_HI = 5'h1D;
  localparam int NUM_SRC = 32;

  // decoded control fields
  typedef struct packed {
    logic pulldown_transistor_off;
    logic pullup_transistor_off;
    logic pin_driver_force_on;
    logic hold_output_only;
    logic test_data;
    logic [4:0] source_select;
  } gpm_ctrl_t;

  // pin driver controls, four signals for the two-way pin
  typedef struct packed {
    logic out;
    logic oe;
    logic pullup_off;
    logic pulldown_off;
  } gpm_pin_t;
endpackage

// >>> rtl/gpm_ctrl_reg.sv
// holds the source control register and answers register reads
// assumes writes and reads arrive as one-cycle strobes in the clock domain
`timescale 1ns/100ps
module gpm_ctrl_reg (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [5:0] i_addr,
  input wire logic [23:0] i_wdata,
  output logic [23:0] o_rdata,
  output gpm_pkg::gpm_ctrl_t o_ctrl
);
  // ************************************************************
  // storage
  // ************************************************************
  logic [23:0] ctrl_r; // only used bits are ever non zero
  logic hit; // address decode

  assign hit = (i_addr == gpm_pkg::OUTPUT_PIN_SOURCE_CONTROL_ADDR);

  // write path; unused bits are dropped so they read as zero
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= gpm_pkg::CTRL_RESET;
    end else if (i_wr_en && hit) begin
      ctrl_r <= {{(gpm_pkg::REG_W - gpm_pkg::USED_BITS){1'b0}},
                 i_wdata[gpm_pkg::USED_BITS-1:0]};
    end
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 24'h000000;
    end else if (i_rd_en) begin
      o_rdata <= hit ? ctrl_r : 24'h000000;
    end
  end

  assign o_ctrl = ctrl_r[gpm_pkg::USED_BITS-1:0];
endmodule

// >>> rtl/gpm_top.sv
// general output pin mux: picks the signal driven on the shared
// lock detect / serial data out pin
// assumes all internal sources and serial read signals are synchronous
// How it works
// - five-bit select picks pin source, resets 1
// - code 0 drives software test data bit
// - codes 1-3 route lock detect signals
// - codes 8-31 route clocks, 26-29 unused
// - bit 6 clear shares pin with read data
// - bit 7 forces driver on, else reads
`timescale 1ns/100ps
module gpm_top #(
  parameter int NUM_SRC = gpm_pkg::NUM_SRC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [5:0] i_addr,
  input wire logic [23:0] i_wdata,
  output logic [23:0] o_rdata,
  input wire logic [NUM_SRC-1:0] i_sources,
  input wire logic i_serial_read_active,
  input wire logic i_serial_read_data,
  output gpm_pkg::gpm_pin_t o_pin
);
  // ************************************************************
  // control register
  // ************************************************************
  gpm_pkg::gpm_ctrl_t ctrl; // decoded fields

  gpm_ctrl_reg u_reg (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_ctrl(ctrl)
  );

  // ************************************************************
  // source mux
  // ************************************************************
  // one candidate per code, so the select is a plain index and the
  // unused band costs nothing but a tied-off bit
  logic [NUM_SRC-1:0] src_vec; // per-code candidate
  logic selected; // general output value
  logic pin_out_nxt; // next pin data
  logic pin_oe_nxt; // next driver enable

  // per code: 0 is test data, unused codes give zero, rest pass through
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      if (g == gpm_pkg::SRC_TEST_DATA) begin : g_test
        assign src_vec[g] = ctrl.test_data;
      end else if (g >= gpm_pkg::SRC_UNUSED_LO &&
                   g <= gpm_pkg::SRC_UNUSED_HI) begin : g_unused
        assign src_vec[g] = 1'b0;
      end else begin : g_pass
        assign src_vec[g] = i_sources[g];
      end
    end
  endgenerate

  assign selected = src_vec[ctrl.source_select];

  // sharing and driver enable
  // read data wins while sharing is allowed, so a host read always
  // sees its own bits; with sharing off the host reads the source
  always_comb begin
    // default: the selected general output
    pin_out_nxt = selected;
    // automatic sharing during a serial read
    if (!ctrl.hold_output_only && i_serial_read_active) begin
      pin_out_nxt = i_serial_read_data;
    end
    // driver on always when forced, otherwise only for a read
    pin_oe_nxt = ctrl.pin_driver_force_on | i_serial_read_active;
  end

  // pin registered so it never glitches between sources
  // the cost is one cycle of latency from any source to the pin
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      // driver off and neither transistor disabled while in reset
      o_pin <= '0;
    end else begin
      o_pin.out <= pin_out_nxt;
      o_pin.oe <= pin_oe_nxt;
      o_pin.pullup_off <= ctrl.pullup_transistor_off;
      o_pin.pulldown_off <= ctrl.pulldown_transistor_off;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // helper terms for the checks, built from the rules on their own
  // rather than from the mux above, so a broken mux cannot hide
  logic show_selected; // no read data competes for the pin
  logic code_unused; // select code in the unused band
  logic code_routed; // select code passes a source straight through

  // the selected source owns the pin when sharing is off or no read runs
  assign show_selected = ctrl.hold_output_only | !i_serial_read_active;
  assign code_unused = (ctrl.source_select >= gpm_pkg::SRC_UNUSED_LO) &&
                       (ctrl.source_select <= gpm_pkg::SRC_UNUSED_HI);
  assign code_routed = !code_unused &&
                       (ctrl.source_select != gpm_pkg::SRC_TEST_DATA);

  // during reset the register holds code 1, both transistors usable
  a_reset_value: assert property (
    @(posedge i_sys_clk)
    i_rst |-> ctrl.source_select == gpm_pkg::SRC_LOCK_DETECT &&
      !ctrl.pullup_transistor_off && !ctrl.pulldown_transistor_off)
    else $error("control not at reset value");

  // a quiet pin in reset keeps the board from seeing a false lock
  a_reset_pin: assert property (
    @(posedge i_sys_clk)
    i_rst |-> o_pin == '0)
    else $error("pin not quiet in reset");

  // code 0 puts the software bit on the pin
  a_test_data_route: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ctrl.source_select == gpm_pkg::SRC_TEST_DATA && show_selected)
    |=> o_pin.out == $past(ctrl.test_data))
    else $error("test data not on pin");

  // code 1 is the lock detect output, the reset choice
  a_lock_route: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ctrl.source_select == gpm_pkg::SRC_LOCK_DETECT && show_selected)
    |=> o_pin.out == $past(i_sources[gpm_pkg::SRC_LOCK_DETECT]))
    else $error("lock detect not on pin");

  // code 2 is the lock detect trigger
  a_trigger_route: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ctrl.source_select == gpm_pkg::SRC_LOCK_TRIGGER && show_selected)
    |=> o_pin.out == $past(i_sources[gpm_pkg::SRC_LOCK_TRIGGER]))
    else $error("lock trigger not on pin");

  // code 3 is the lock detect window output
  a_window_route: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ctrl.source_select == gpm_pkg::SRC_LOCK_WINDOW && show_selected)
    |=> o_pin.out == $past(i_sources[gpm_pkg::SRC_LOCK_WINDOW]))
    else $error("lock window not on pin");

  // every used code other than 0 passes its own source bit
  // a wrong index in the mux shows up here for any routed code
  a_source_pass: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (code_routed && show_selected)
    |=> o_pin.out == $past(i_sources[ctrl.source_select]))
    else $error("selected source not on pin");

  // unused codes hold the pin low instead of floating a stray source
  a_unused_zero: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (code_unused && show_selected)
    |=> !o_pin.out)
    else $error("unused code drives pin");

  // with sharing allowed, a read puts its own data on the pin
  a_share_read: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (!ctrl.hold_output_only && i_serial_read_active)
    |=> o_pin.out == $past(i_serial_read_data))
    else $error("read data not shared");

  // with sharing off, read activity never reaches the pin data
  a_hold_only: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    ctrl.hold_output_only
    |=> o_pin.out == $past(selected))
    else $error("output not held");

  // forced driver stays on whatever the read state
  a_driver_force: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    ctrl.pin_driver_force_on
    |=> o_pin.oe)
    else $error("driver not forced on");

  // otherwise the driver follows the read cycle exactly
  a_driver_read: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !ctrl.pin_driver_force_on
    |=> o_pin.oe == $past(i_serial_read_active))
    else $error("driver enable wrong");

  // pull-up disable follows its own bit, one cycle late
  a_pullup_ctrl: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    1'b1
    |=> o_pin.pullup_off == $past(ctrl.pullup_transistor_off))
    else $error("pull-up control wrong");

  // pull-down disable follows its own bit, one cycle late
  a_pulldown_ctrl: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    1'b1
    |=> o_pin.pulldown_off == $past(ctrl.pulldown_transistor_off))
    else $error("pull-down control wrong");

  // bits that are not stored always read back as zero
  a_rdata_upper: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    1'b1
    |-> o_rdata[gpm_pkg::REG_W-1:gpm_pkg::USED_BITS] == '0)
    else $error("unused read bits set");

  // a read of the control offset returns the fields then in force
  a_rdata_mapped: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_rd_en && i_addr == gpm_pkg::OUTPUT_PIN_SOURCE_CONTROL_ADDR)
    |=> o_rdata[gpm_pkg::USED_BITS-1:0] == $past(ctrl))
    else $error("read data wrong");
endmodule

// >>> testbench/gpm_host_model.sv
// far side model: serial host that runs read cycles on the pin
// assumes the bench clock; read status changes at the falling edge
`timescale 1ns/100ps
module gpm_host_model (
  input wire logic i_sys_clk,
  input wire logic i_read_req,
  input wire logic i_read_bit,
  output logic o_read_active,
  output logic o_read_data
);
  // idle data toggles so a stale bit can never pass for a match
  initial begin
    o_read_active = 1'b0;
    o_read_data = 1'b0;
  end
  // one cycle from request to read status
  always @(negedge i_sys_clk) begin
    o_read_active <= i_read_req;
    o_read_data <= i_read_req ? i_read_bit : ~o_read_data;
  end
endmodule

// >>> testbench/test_gpm_top.sv
// bench for the pin mux: a table of pin cases, then reset, width
// and address checks; assumes the host model drives read status
`timescale 1ns/100ps
module test_gpm_top;
  logic i_sys_clk, i_rst, i_wr_en, i_rd_en, req, rbit, act, rdat;
  logic [5:0] i_addr;
  logic [23:0] i_wdata, o_rdata;
  logic [31:0] i_sources;
  gpm_pkg::gpm_pin_t o_pin;
  int fail_count = 0;
  int n_compared = 0;
  // row: {out,oe,pu_off,pd_off}, read bit, read req, source, control
  logic [16:0] rows [16] = '{{4'hC,3'h1,10'h081}, {4'h4,3'h0,10'h081},
    {4'hC,3'h1,10'h082}, {4'h4,3'h0,10'h083}, {4'hC,3'h0,10'h0A0},
    {4'h4,3'h1,10'h080}, {4'hC,3'h1,10'h088}, {4'h4,3'h0,10'h090},
    {4'hC,3'h1,10'h09F}, {4'h4,3'h1,10'h09A}, {4'h4,3'h1,10'h09D},
    {4'h4,3'h3,10'h001}, {4'hD,3'h3,10'h241}, {4'hA,3'h1,10'h101},
    {4'hC,3'h6,10'h081}, {4'hF,3'h1,10'h381}};
  gpm_top u_gpm_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_sources(i_sources),
    .i_serial_read_active(act), .i_serial_read_data(rdat),
    .o_pin(o_pin));
  gpm_host_model u_gpm_host_model (.i_sys_clk(i_sys_clk),
    .i_read_req(req), .i_read_bit(rbit), .o_read_active(act),
    .o_read_data(rdat));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // caller stands at a falling edge; strobes last one cycle
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr_en <= 1'b1;
    @(negedge i_sys_clk) i_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(negedge i_sys_clk) i_rd_en <= 1'b0;
    @(negedge i_sys_clk) chk(o_rdata, e);
  endtask
  // pin must be quiet at the end of 20 cycles of reset
  task automatic do_reset;
    i_rst <= 1'b1;
    repeat (20) @(negedge i_sys_clk);
    chk({20'h0, o_pin}, 24'h0);
    i_rst <= 1'b0;
    @(negedge i_sys_clk);
  endtask
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  // cut a hang well past the expected run of about 120 cycles
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
  initial begin
    {i_rst, i_wr_en, i_rd_en, req, rbit} = 5'h10;
    i_addr = 6'h00;
    i_wdata = 24'h0;
    i_sources = 32'h0;
    do_reset();
    // one-hot or inverted sources expose a wrong code
    for (int k = 0; k < 16; k++) begin
      wr(6'h0F, {14'h0, rows[k][9:0]});
      i_sources <= rows[k][10] ? 32'h1 << rows[k][4:0]
                               : ~(32'h1 << rows[k][4:0]);
      req <= rows[k][11];
      rbit <= rows[k][12];
      repeat (3) @(negedge i_sys_clk);
      chk({20'h0, o_pin}, {20'h0, rows[k][16:13]});
    end
    // mid-run reset restores code 1 with the driver off outside reads
    req <= 1'b0;
    i_sources <= 32'h2;
    do_reset();
    rd(6'h0F, 24'h000001);
    chk({20'h0, o_pin}, 24'h8);
    wr(6'h0F, 24'hFFFFFF);
    rd(6'h0F, 24'h0003FF);
    wr(6'h0E, 24'h0);
    rd(6'h0F, 24'h0003FF);
    rd(6'h0E, 24'h0);
    final_report();
  end
endmodule
